// [design/sar_conv_defs.svh]
// timing counts and field layout of the conversion sequencer link
`ifndef SAR_CONV_DEFS_SVH
`define SAR_CONV_DEFS_SVH
`define CLK_PERIOD_NS 25
`define START_MIN_NS 100
`define START_MIN_CYC ((`START_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DONE_DELAY_NS 40
`define DONE_DELAY_CYC ((`DONE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LSB_LEAD_NS 20
`define LSB_LEAD_CYC (((`LSB_LEAD_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`LSB_LEAD_NS / `CLK_PERIOD_NS))
`define CONV_CLOCKS 13
`define RESULT_WIDTH 12
`define FULL_RES 4'hc
`define STEP_CLOCKS 4
`define RESET_DATA_N 12'hfff
`define RESET_MSB_INV 1'b1
`endif

// [design/sar_conv_pkg.sv]
// state and coding types for the two ends of the conversion link
package sar_conv_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_SETTLE} conv_state_t;
    typedef enum logic [1:0] {HOST_IDLE, HOST_PULSE, HOST_WAIT} host_state_t;
    typedef enum logic [1:0] {
        complement_straight_binary,
        complement_offset_binary,
        complement_twos_complement
    } code_mode_t;
endpackage

// [design/sar_conv_if.sv]
// link between the host and the converter sequencer
`timescale 1ns/10ps
`default_nettype none
interface sar_conv_if;
    logic convStart;
    logic status;
    logic convClock;
    logic [11:0] dataOutN;
    logic msbInvN;
    logic [3:0] shortCycle;
    modport converter(input convStart, input shortCycle, output status, output convClock,
        output dataOutN, output msbInvN);
    modport host(output convStart, output shortCycle, input status, input convClock,
        input dataOutN, input msbInvN);
endinterface
`default_nettype wire

// [design/sar_conv_device.sv]
// converter end: successive approximation sequencer with gated clock
// Overview of operation
// - host start pulse at least 100 ns
// - host holds start low during conversion
// - start trailing edge initializes register, status, inhibit
// - status high throughout conversion
// - gated clock runs exactly 13 cycles
// - 12-bit register feeds outputs and DAC, MSB first
// - first step clears bit 1, sets rest
// - keep/reject bit n, clear bit n+1
// - status falls 40 ns after last decision
// - final word on the pins 20 ns before status falls
// - status reset re-inhibits clock, held low
// - outputs change on rising conversion clock; the final word goes out in ST_SETTLE with the clock low
// - 13 falling edges, first bit invalid
// - result complemented, straight binary for unipolar
// - true and inverted MSB both provided
// - host latches result on status fall
// - short cycle ends after selected bit count
`timescale 1ns/10ps
`default_nettype none
`include "sar_conv_defs.svh"
module sar_conv_device #(
    // settle time after the last decision and length of one bit step
    parameter int SETTLE_CYC = `DONE_DELAY_CYC,
    parameter int STEP_CYC = `STEP_CLOCKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link to host
    sar_conv_if.converter link,
    // analog side: comparator result and trial word to the dac
    input wire logic compHigh,
    output logic [11:0] dacCode
);
    import sar_conv_pkg::*;

    // phase numbers inside one bit step of the gated clock
    localparam logic [2:0] PH_RISE = 3'h0;
    localparam logic [2:0] PH_FALL = 3'(STEP_CYC - 1);

    typedef struct packed {
        // input history and comparator synchroniser
        logic startPrev;
        logic compSync1;
        logic compSync2;
        // conversion progress
        conv_state_t state;
        logic [11:0] approx;
        logic [3:0] step;
        logic [3:0] bitsWanted;
        logic [1:0] settle;
        logic [2:0] phase;
        // registered outputs
        logic clkOut;
        logic status;
        logic [11:0] dataN;
        logic msbInvN;
        logic [11:0] dac;
    } dev_state_t;

    dev_state_t st_reg, st_next;
    logic [3:0] limit;
    logic startFall;
    logic keepBit;

    // trailing edge of the start pulse; same clock, no synchroniser
    assign startFall = st_reg.startPrev && !link.convStart;
    // comparator high means the trial is above the input: reject
    assign keepBit = ~st_reg.compSync2;

    // chosen resolution, clamped to 1..12
    // zero or a count above twelve selects full resolution
    always_comb begin
        if (st_reg.bitsWanted == 4'h0 || st_reg.bitsWanted > `FULL_RES) begin
            limit = `FULL_RES;
        end else begin
            limit = st_reg.bitsWanted;
        end
    end

    // one bit step, phase by phase:
    //   phase 0: gated clock rises, dac and data pins take the register
    //   phase 1: comparator sees the new trial, first flip-flop takes it
    //   phase 2: second flip-flop takes the comparator result
    //   phase 3: gated clock falls, bit kept or rejected, next trial opened
    // the high time is what lets the comparator pass its two flip-flops
    // the first falling edge decides nothing: its bit is the invalid one
    // a step count equal to the chosen resolution ends the conversion
    always_comb begin
        // every field holds unless changed below
        st_next = st_reg;
        // start edge history
        st_next.startPrev = link.convStart;
        // comparator is asynchronous: two flip-flops before use
        st_next.compSync1 = compHigh;
        st_next.compSync2 = st_reg.compSync1;
        case (st_reg.state)
            ST_IDLE: begin
                st_next.clkOut = 1'b0;
                st_next.phase = 3'h0;
                // trailing edge of start begins a conversion
                if (startFall) begin
                    st_next.state = ST_CONVERT;
                    st_next.status = 1'b1;
                    st_next.step = 4'h0;
                    st_next.bitsWanted = link.shortCycle;
                    // msb pin reset and the rest set: true trial is the msb alone
                    st_next.approx = 12'h800;
                    st_next.dac = 12'h800;
                end
            end
            ST_CONVERT: begin
                // gated clock released while status is high; later starts ignored
                st_next.phase = st_reg.phase + 3'h1;
                case (st_reg.phase)
                    PH_RISE: begin
                        // rising edge: outputs follow register
                        st_next.clkOut = 1'b1;
                        st_next.dac = st_reg.approx;
                        st_next.dataN = ~st_reg.approx;
                        st_next.msbInvN = st_reg.approx[11];
                    end
                    PH_FALL: begin
                        // falling edge: decide bit, open next trial
                        st_next.clkOut = 1'b0;
                        st_next.phase = 3'h0;
                        // walk the register: one bit decided, the next one opened
                        for (int b = 0; b < 12; b++) begin
                            if (st_reg.step == 4'(12 - b)) begin
                                // keep or reject the bit under test
                                st_next.approx[b] = keepBit;
                            end
                            if (st_reg.step == 4'(11 - b)) begin
                                // resetting the next negative-true pin sets its trial
                                st_next.approx[b] = 1'b1;
                            end
                        end
                        st_next.step = st_reg.step + 4'h1;
                        if (st_reg.step == limit) begin
                            // last decision made, clock stays low
                            st_next.state = ST_SETTLE;
                            st_next.settle = 2'(SETTLE_CYC);
                        end
                    end
                    default: begin
                        // clock held high while the trial settles
                        st_next.clkOut = 1'b1;
                    end
                endcase
            end
            ST_SETTLE: begin
                // clock held low, pins show the final word
                st_next.clkOut = 1'b0;
                st_next.dac = st_reg.approx;
                st_next.dataN = ~st_reg.approx;
                st_next.msbInvN = st_reg.approx[11];
                // status drops once the settle count runs out
                st_next.settle = st_reg.settle - 2'h1;
                if (st_reg.settle <= 2'h1) begin
                    st_next.status = 1'b0;
                    st_next.state = ST_IDLE; // result held
                end
            end
            default: begin
                // unused encoding falls back to idle
                st_next.state = ST_IDLE;
            end
        endcase
    end

    // state register; reset loads constants only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{
                startPrev: 1'b0,
                compSync1: 1'b0,
                compSync2: 1'b0,
                state: ST_IDLE,
                approx: 12'h000,
                step: 4'h0,
                bitsWanted: `FULL_RES,
                settle: 2'h0,
                phase: 3'h0,
                clkOut: 1'b0,
                status: 1'b0,
                dataN: `RESET_DATA_N,
                msbInvN: `RESET_MSB_INV,
                dac: 12'h000
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // link outputs straight from the state register
    assign link.status = st_reg.status;
    assign link.convClock = st_reg.clkOut;
    assign link.dataOutN = st_reg.dataN;
    assign link.msbInvN = st_reg.msbInvN;

    // trial word to the dac
    assign dacCode = st_reg.dac;
endmodule
`default_nettype wire

// [design/sar_conv_host.sv]
// host end: issues start pulses and latches the result on status fall
`timescale 1ns/10ps
`default_nettype none
`include "sar_conv_defs.svh"
module sar_conv_host (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // user side
    input wire logic startReq,
    input wire logic [3:0] resolution,
    input wire sar_conv_pkg::code_mode_t codeMode,
    output logic busy,
    output logic resultValid,
    output logic [11:0] result,
    // link to converter
    sar_conv_if.host link
);
    import sar_conv_pkg::*;

    localparam int PULSE_CYC = `START_MIN_CYC;

    typedef struct packed {
        host_state_t state;
        logic [2:0] count;
        logic start;
        logic [3:0] res;
        logic statPrev;
        logic busy;
        logic valid;
        logic [11:0] word;
    } host_reg_t;

    host_reg_t h_reg, h_next;

    // start pulse of at least 100 ns, then held low until done
    always_comb begin
        h_next = h_reg;
        h_next.statPrev = link.status; // same clock: no synchroniser
        h_next.valid = 1'b0;
        case (h_reg.state)
            HOST_IDLE: begin
                if (startReq) begin
                    h_next.state = HOST_PULSE;
                    h_next.start = 1'b1;
                    h_next.res = resolution;
                    h_next.busy = 1'b1;
                    h_next.count = 3'(PULSE_CYC);
                end
            end
            HOST_PULSE: begin
                h_next.count = h_reg.count - 3'h1;
                if (h_reg.count <= 3'h1) begin
                    h_next.start = 1'b0;
                    h_next.state = HOST_WAIT;
                end
            end
            HOST_WAIT: begin
                // latch on the falling status edge
                if (h_reg.statPrev && !link.status) begin
                    h_next.valid = 1'b1;
                    h_next.busy = 1'b0;
                    h_next.state = HOST_IDLE;
                    // coding picked by MSB choice
                    case (codeMode)
                        complement_twos_complement:
                            h_next.word = {link.msbInvN, link.dataOutN[10:0]};
                        default: h_next.word = link.dataOutN;
                    endcase
                end
            end
            default: begin
                h_next.state = HOST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            h_reg <= '{state: HOST_IDLE, res: `FULL_RES, default: '0};
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.convStart = h_reg.start;
    assign link.shortCycle = h_reg.res;
    assign busy = h_reg.busy;
    assign resultValid = h_reg.valid;
    assign result = h_reg.word;
endmodule
`default_nettype wire

// [verif/sar_conv_monitor.sv]
// assertions on the host to converter link
`timescale 1ns/10ps
`default_nettype none
module sar_conv_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link signals
    input wire logic convStart,
    input wire logic status,
    input wire logic convClock,
    input wire logic [11:0] dataOutN,
    input wire logic msbInvN,
    input wire logic [3:0] shortCycle
);
    logic [4:0] rises_reg;
    logic clkPrev_reg;
    logic [4:0] limit;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // number of decisions the converter should make
    assign limit = (shortCycle == 4'h0 || shortCycle > 4'hc) ? 5'hc : {1'b0, shortCycle};
    // count gated clock rises inside one conversion
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rises_reg <= 5'h0;
            clkPrev_reg <= 1'b0;
        end else begin
            clkPrev_reg <= convClock;
            if (!status) begin
                rises_reg <= 5'h0;
            end else if (convClock && !clkPrev_reg) begin
                rises_reg <= rises_reg + 5'h1;
            end
        end
    end
    AST_START_TO_STATUS: assert property ($fell(convStart) |-> ##[1:4] status)
        else $error("status did not follow start");
    AST_STATUS_HOLDS: assert property ($rose(status) |-> status [*4])
        else $error("status dropped early");
    AST_START_LOW: assert property (status |-> !convStart)
        else $error("start high during conversion");
    AST_START_WIDTH: assert property ($rose(convStart) |-> convStart [*4])
        else $error("start pulse too short");
    AST_CLOCK_INHIBIT: assert property (!status |-> !convClock)
        else $error("clock runs while idle");
    AST_CLOCK_COUNT: assert property ($fell(status) |-> rises_reg == limit + 5'h1)
        else $error("wrong gated clock count");
    AST_SETTLE: assert property ($fell(status) |->
        !$past(convClock) && !$past(convClock, 2))
        else $error("status fell without settle delay");
    AST_MSB_PAIR: assert property ($fell(status) |-> msbInvN != dataOutN[11])
        else $error("inverted msb wrong");
    AST_RESULT_HOLD: assert property ($fell(status) |=> $stable(dataOutN) [*3])
        else $error("result changed after done");
endmodule
`default_nettype wire

// [verif/test_sar_conversion_sequencer.sv]
// self-checking bench: host and converter joined by the link
`timescale 1ns/10ps
`default_nettype none
module test_sar_conversion_sequencer;
    import sar_conv_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic startReq = 1'b0;
    logic [3:0] resolution = 4'hc;
    code_mode_t codeMode = complement_straight_binary;
    logic [11:0] vin = 12'h0;
    logic busy, resultValid, compHigh;
    logic [11:0] result, dacCode;
    int num_errors = 0;
    int check_count = 0;
    logic [11:0] vins [9] = '{12'h676, 12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h3a5, 12'hc3c,
        12'h009, 12'h555};
    logic [3:0] ress [9] = '{4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'ha, 4'h8, 4'h1, 4'h0};
    sar_conv_if link();
    sar_conv_device i_sar_conv_device (.ref_clk(ref_clk), .reset(reset), .link(link.converter),
        .compHigh(compHigh), .dacCode(dacCode));
    sar_conv_host i_sar_conv_host (.ref_clk(ref_clk), .reset(reset), .startReq(startReq),
        .resolution(resolution), .codeMode(codeMode), .busy(busy), .resultValid(resultValid),
        .result(result), .link(link.host));
    sar_conv_monitor i_sar_conv_monitor (.ref_clk(ref_clk), .reset(reset),
        .convStart(link.convStart), .status(link.status), .convClock(link.convClock),
        .dataOutN(link.dataOutN), .msbInvN(link.msbInvN), .shortCycle(link.shortCycle));
    // comparator: input below the trial word rejects the bit
    assign compHigh = (vin < dacCode);
    // clock
    always #12.5 ref_clk = ~ref_clk;
    // verdict and end of run
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one comparison
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one conversion through the host, then checks of result and link
    task automatic convert(input logic [11:0] v, input logic [3:0] res, input code_mode_t m);
        int n;
        logic [3:0] lim;
        logic [11:0] mask;
        logic [11:0] exp;
        vin = v;
        resolution = res;
        codeMode = m;
        startReq = 1'b1;
        @(posedge ref_clk);
        #1;
        startReq = 1'b0;
        n = 0;
        while (resultValid !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("resultValid", 12'h1, {11'h0, resultValid});
        lim = (res == 4'h0 || res > 4'hc) ? 4'hc : res;
        mask = 12'hfff << (4'hc - lim);
        exp = ~v;
        if (m == complement_twos_complement) begin
            exp[11] = v[11];
        end
        check("result", exp & mask, result & mask);
        repeat (4) @(posedge ref_clk);
        #1;
        check("dataOutN", ~v & mask, link.dataOutN & mask);
        check("dacCode", v & mask, dacCode & mask);
        check("msbInvN", {11'h0, v[11]}, {11'h0, link.msbInvN});
        check("busy", 12'h0, {11'h0, busy});
    endtask
    // watchdog
    initial begin
        #(25 * 8000);
        num_errors++;
        conclude();
    end
    // reset, then a table of nine conversions over all three codings and resolutions 12, 10, 8, 1 and 0
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 9; i++) begin
            convert(vins[i], ress[i], code_mode_t'(i % 3));
        end
        conclude();
    end
endmodule
`default_nettype wire
